/* File: verilog/lcdc_consts.vh */
// constants for the dot-matrix lcd command decoder
// assumes inclusion by verilog/lcdc_decoder.v only
`ifndef LCDC_CONSTS_VH
`define LCDC_CONSTS_VH
`define LCDC_CMD_DISP_OFF   8'hAE
`define LCDC_CMD_DISP_ON    8'hAF
`define LCDC_CMD_SEG_FWD    8'hA0
`define LCDC_CMD_SEG_REV    8'hA1
`define LCDC_CMD_STATIC_OFF 8'hA4
`define LCDC_CMD_STATIC_ON  8'hA5
`define LCDC_CMD_DUTY16     8'hA8
`define LCDC_CMD_DUTY32     8'hA9
`define LCDC_CMD_RMW_ON     8'hE0
`define LCDC_CMD_RMW_END    8'hEE
`define LCDC_CMD_SW_RESET   8'hE2
`define LCDC_CMD_PAGE_MASK  8'hFC
`define LCDC_CMD_PAGE_BASE  8'hB8
`define LCDC_CMD_LINE_MASK  8'hE0
`define LCDC_CMD_LINE_BASE  8'hC0
`define LCDC_COL_LAST       7'h4F
`define LCDC_COL_STOP       7'h50
`define LCDC_RST_LINE       5'h01
`define LCDC_RST_PAGE       2'h3
`define LCDC_ST_BUSY        7
`define LCDC_ST_SEG         6
`define LCDC_ST_OFF         5
`define LCDC_ST_RESET       4
`define LCDC_CMD_TIME_NS    100
`define LCDC_RST_TIME_NS    1000
`define LCDC_CLK_NS         50
`define LCDC_CMD_CYC        ((`LCDC_CMD_TIME_NS + `LCDC_CLK_NS - 1) / `LCDC_CLK_NS)
`define LCDC_RST_CYC        ((`LCDC_RST_TIME_NS + `LCDC_CLK_NS - 1) / `LCDC_CLK_NS)
`endif

/* File: verilog/lcdc_decoder.v */
// command decoder and display-ram addressing of an 80x32 dot-matrix lcd driver
// assumes host strobes and data on pins, strobes sampled through three flip-flops, data through two
//
// Overview of operation
// RQ1: AEH turns panel drive off, AFH on; nothing else changes.
// RQ2: C0H..DFH load low five bits into the start line register.
// RQ3: displayed lines run upward from start line for duty lines.
// RQ4: page command loads two-bit page register; display unaffected.
// RQ5: 00H..4FH load the seven-bit column address register.
// RQ6: column increments after each data access, stops at 80, page fixed.
// RQ7: status read gives busy, segment order, off, reset, zeros below.
// RQ8: busy while executing or resetting; commands refused; host waits.
// RQ9: segment status 1 for forward order, 0 for inverted order.
// RQ10: off status is inverse of last on/off command.
// RQ11: reset status is 1 while hardware or software reset runs.
// RQ12: data write stores byte at page and column, then column increments.
// RQ13: data read returns latch, refills from ram, column increments.
// RQ14: host discards one read after loading a column address.
// RQ15: A0H/A1H select segment order; module uses A0H.
// RQ16: A5H forces static drive with all commons selected; A4H normal.
// RQ17: A8H/A9H select 1/16 or 1/32 duty; module uses 1/32.
// RQ18: read-modify-write saves column, suppresses increment after reads.
// RQ19: EEH ends read-modify-write and restores the saved column.
// RQ20: E2H sets start line 1, page 3; ram untouched.
// RQ21: host must pulse hardware reset at power-up.
// RQ22: hardware reset edge sets the documented initial state.
// RQ23: unknown command bytes change nothing; busy for normal time.
`timescale 1ns/10ps
`include "lcdc_consts.vh"
module lcdc_decoder #(
  parameter CMD_CYC = `LCDC_CMD_CYC,
  parameter RST_CYC = `LCDC_RST_CYC
) (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       hardware_reset_input,
  input  wire       command_data_select,
  input  wire       rd_n,
  input  wire       wr_n,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg  [7:0] data_oe_n,
  output reg        display_on,
  output reg        static_drive,
  output reg        duty_32,
  output reg        seg_forward,
  output reg  [4:0] start_line,
  output reg  [4:0] line_count_m1,
  output reg  [6:0] scan_col,
  output reg  [4:0] scan_line,
  output reg  [7:0] scan_data
);
  localparam ST_IDLE = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_RST  = 3'b100;

  // three-stage synchronisers; change counts when stages 2 and 3 agree
  reg  [2:0] s_hres, s_cd, s_rd, s_wr;
  reg  [7:0] d1, d2;
  reg        hres_q, rd_q, wr_q;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_hres <= 3'h0;
      s_cd   <= 3'h0;
      s_rd   <= 3'h7;
      s_wr   <= 3'h7;
      d1     <= 8'h00;
      d2     <= 8'h00;
      hres_q <= 1'b0;
      rd_q   <= 1'b1;
      wr_q   <= 1'b1;
    end else begin
      s_hres <= {s_hres[1:0], hardware_reset_input};
      s_cd   <= {s_cd[1:0], command_data_select};
      s_rd   <= {s_rd[1:0], rd_n};
      s_wr   <= {s_wr[1:0], wr_n};
      d1 <= data_in;
      d2 <= d1;
      if (s_hres[1] == s_hres[2]) hres_q <= s_hres[2];
      if (s_rd[1] == s_rd[2]) rd_q <= s_rd[2];
      if (s_wr[1] == s_wr[2]) wr_q <= s_wr[2];
    end
  end
  wire hres_edge = (s_hres[1] == s_hres[2]) && (s_hres[2] != hres_q);
  // write acts on the rising edge of the strobe, data held by then
  wire wr_done   = (s_wr[1] == s_wr[2]) && s_wr[2] && !wr_q;
  wire rd_start  = (s_rd[1] == s_rd[2]) && !s_rd[2] && rd_q;
  wire rd_end    = (s_rd[1] == s_rd[2]) && s_rd[2] && !rd_q;
  wire cd        = s_cd[2];

  reg [7:0] ram [0:319];
  reg [2:0] state;
  reg [9:0] cnt;
  reg [1:0] page;
  reg [6:0] col, col_saved;
  reg       rmw;
  reg [7:0] io_latch;
  reg       rd_is_data;
  reg [4:0] scan_ofs;
  reg [6:0] scan_pos;
  wire       busy = (state != ST_IDLE);
  // linear index: page*80 + col
  wire [8:0] ram_addr = {2'b00, page, 5'h00} * 9'd2 + {2'b00, page, 5'h00} / 9'd2
                        + {2'b00, col};
  wire [6:0] col_inc = (col < `LCDC_COL_STOP) ? col + 7'h01 : col; // see RQ6
  wire [4:0] line_sum = start_line + scan_ofs; // see RQ3
  wire [6:0] seg_col = seg_forward ? scan_pos : `LCDC_COL_LAST - scan_pos; // see RQ9
  wire [8:0] scan_addr = {2'b00, line_sum[4:3], 5'h00} * 9'd2
                         + {2'b00, line_sum[4:3], 5'h00} / 9'd2 + {2'b00, seg_col};

  always @(posedge clk) begin
    // column 80 is a parking spot: its index would alias column 0 of the next page
    if (!busy && wr_done && cd && !hres_edge && col < `LCDC_COL_STOP)
      ram[ram_addr] <= d2; // see RQ12
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state        <= ST_RST;
      cnt          <= 10'h000;
      display_on   <= 1'b0;
      static_drive <= 1'b0;
      duty_32      <= 1'b1;
      seg_forward  <= 1'b1;
      start_line   <= `LCDC_RST_LINE;
      page         <= `LCDC_RST_PAGE;
      col          <= 7'h00;
      col_saved    <= 7'h00;
      rmw          <= 1'b0;
      io_latch     <= 8'h00;
      rd_is_data   <= 1'b0;
      data_out     <= 8'h00;
      data_oe_n    <= 8'hFF;
    end else if (hres_edge) begin
      // see RQ22
      state        <= ST_RST;
      cnt          <= 10'h000;
      display_on   <= 1'b0;
      static_drive <= 1'b0;
      duty_32      <= 1'b1;
      seg_forward  <= 1'b1;
      start_line   <= `LCDC_RST_LINE;
      page         <= `LCDC_RST_PAGE;
      col          <= 7'h00;
      rmw          <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (wr_done && cd) begin
            col <= col_inc; // see RQ12
          end else if (wr_done) begin
            // see RQ8
            state <= ST_EXEC;
            cnt   <= 10'h000;
            if (!d2[7] && d2[6:0] <= `LCDC_COL_LAST) col <= d2[6:0]; // see RQ5
            else if ((d2 & `LCDC_CMD_LINE_MASK) == `LCDC_CMD_LINE_BASE)
              start_line <= d2[4:0]; // see RQ2
            else if ((d2 & `LCDC_CMD_PAGE_MASK) == `LCDC_CMD_PAGE_BASE)
              page <= d2[1:0]; // see RQ4
            else case (d2)
              `LCDC_CMD_DISP_OFF, `LCDC_CMD_DISP_ON: display_on <= d2[0]; // see RQ1
              `LCDC_CMD_SEG_FWD, `LCDC_CMD_SEG_REV: seg_forward <= ~d2[0]; // see RQ15
              `LCDC_CMD_STATIC_OFF, `LCDC_CMD_STATIC_ON: static_drive <= d2[0]; // see RQ16
              `LCDC_CMD_DUTY16, `LCDC_CMD_DUTY32: duty_32 <= d2[0]; // see RQ17
              `LCDC_CMD_RMW_ON: begin
                rmw <= 1'b1; // see RQ18
                col_saved <= col;
              end
              `LCDC_CMD_RMW_END: begin
                rmw <= 1'b0; // see RQ19
                if (rmw) col <= col_saved;
              end
              `LCDC_CMD_SW_RESET: begin
                state <= ST_RST; // see RQ20
                start_line <= `LCDC_RST_LINE;
                page <= `LCDC_RST_PAGE;
              end
              default: ; // see RQ23
            endcase
          end
        end
        ST_EXEC: begin
          cnt <= cnt + 10'h001;
          if (cnt >= CMD_CYC - 1) state <= ST_IDLE; // see RQ8
        end
        ST_RST: begin
          cnt <= cnt + 10'h001;
          if (cnt >= RST_CYC - 1) state <= ST_IDLE; // see RQ11
        end
        default: state <= ST_IDLE;
      endcase
      // reads are served in any state so status stays visible while busy
      if (rd_start) begin
        data_oe_n <= 8'h00;
        rd_is_data <= cd;
        if (cd) data_out <= io_latch; // see RQ13
        else data_out <= {busy, seg_forward, ~display_on, state == ST_RST, 4'h0}; // see RQ7 RQ10
      end else if (rd_end) begin
        data_oe_n <= 8'hFF;
        if (rd_is_data && !busy) begin
          io_latch <= (col < `LCDC_COL_STOP) ? ram[ram_addr] : 8'h00; // see RQ13
          if (!rmw) col <= col_inc; // see RQ18
        end
      end
    end
  end

  // panel scan: walk lines from the start line for the selected duty
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scan_ofs  <= 5'h00;
      scan_pos  <= 7'h00;
      scan_col  <= 7'h00;
      scan_line <= 5'h00;
      scan_data <= 8'h00;
      line_count_m1 <= 5'h1F;
    end else begin
      line_count_m1 <= duty_32 ? 5'h1F : 5'h0F; // see RQ3
      if (scan_pos == `LCDC_COL_LAST) begin
        scan_pos <= 7'h00;
        scan_ofs <= (scan_ofs >= line_count_m1) ? 5'h00 : scan_ofs + 5'h01;
      end else begin
        scan_pos <= scan_pos + 7'h01;
      end
      scan_col  <= scan_pos;
      scan_line <= line_sum;
      scan_data <= static_drive ? 8'hFF : (display_on ? ram[scan_addr] : 8'h00); // see RQ16
    end
  end
endmodule // lcdc_decoder

/* File: dv/lcdc_sva.sv */
// pin-level assertions for the lcd command decoder
// assumes the host waits for ready before every command
`timescale 1ns/10ps
module lcdc_sva (
  input wire       clk,
  input wire       sys_rst,
  input wire       hardware_reset_input,
  input wire       command_data_select,
  input wire       rd_n,
  input wire       wr_n,
  input wire [7:0] data_in,
  input wire [7:0] data_out,
  input wire [7:0] data_oe_n,
  input wire       display_on,
  input wire       duty_32,
  input wire [4:0] start_line,
  input wire [4:0] line_count_m1
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence wr_cmd(v);
    !wr_n && !command_data_select && data_in == v ##1 wr_n;
  endsequence
  // the effect of a write or a reset edge lands a few clocks late, so wait eight
  sequence quiet;
    (wr_n && $stable(hardware_reset_input)) [*8];
  endsequence
  property p_line;
    logic [4:0] v;
    (!wr_n && !command_data_select && data_in[7:5] == 3'b110, v = data_in[4:0]) ##1 wr_n
      |-> ##[1:8] start_line == v;
  endproperty
  a_reset_state: assert property (disable iff (1'b0) sys_rst [*2] |-> !display_on && duty_32
    && start_line == 5'h01 && data_oe_n == 8'hFF) else $error("reset state wrong");
  a_oe_drive: assert property (($fell(rd_n) ##1 !rd_n [*5]) |-> data_oe_n == 8'h00)
    else $error("read bus not driven");
  a_oe_release: assert property (rd_n [*6] |-> data_oe_n == 8'hFF) else $error("bus not freed");
  a_status_zero: assert property ((!rd_n && !command_data_select) [*6]
    |-> data_out[3:0] == 4'h0) else $error("status low bits set");
  a_disp_on: assert property (wr_cmd(8'hAF) |-> ##[1:8] display_on)
    else $error("display not on");
  a_disp_off: assert property (wr_cmd(8'hAE) |-> ##[1:8] !display_on)
    else $error("display not off");
  a_line_load: assert property (p_line) else $error("start line not loaded");
  a_duty_lines: assert property ($stable(duty_32) [*3]
    |-> line_count_m1 == (duty_32 ? 5'h1F : 5'h0F)) else $error("line count wrong");
  a_quiet_stable: assert property (quiet |-> $stable({display_on, duty_32, start_line}))
    else $error("setting moved without a write");
endmodule // lcdc_sva
bind lcdc_decoder lcdc_sva i_lcdc_sva (.clk(clk), .sys_rst(sys_rst),
  .hardware_reset_input(hardware_reset_input), .command_data_select(command_data_select),
  .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
  .display_on(display_on), .duty_32(duty_32), .start_line(start_line),
  .line_count_m1(line_count_m1));

/* File: dv/lcdc_host.sv */
// host microprocessor model on the parallel bus
// assumes a free-running clk; the bench calls its tasks
`timescale 1ns/10ps
module lcdc_host (
  input  wire       clk,
  input  wire [7:0] data_out,
  output reg        hardware_reset_input,
  output reg        command_data_select,
  output reg        rd_n,
  output reg        wr_n,
  output reg  [7:0] data_in
);
  reg [7:0] s;
  integer   k;
  initial begin
    {hardware_reset_input, command_data_select, rd_n, wr_n, data_in} = 12'h3FF;
  end
  task automatic strobe(input reg rd, input reg sel, input reg [7:0] v, output reg [7:0] q);
    @(negedge clk);
    command_data_select = sel;
    data_in = v;
    rd_n = !rd;
    wr_n = rd;
    repeat (6) @(negedge clk);
    q = data_out;
    {rd_n, wr_n} = 2'h3;
    repeat (6) @(negedge clk);
    data_in = ~v; // released bus must not keep looking valid
  endtask
  task automatic ready;
    k = 0;
    s = 8'hFF;
    while (s[7] !== 1'b0 && k < 80) begin
      strobe(1, 0, 8'h00, s);
      k++;
    end
  endtask
  task automatic put(input reg sel, input reg [7:0] v);
    reg [7:0] x;
    ready;
    strobe(0, sel, v, x);
  endtask
  task automatic get(input reg sel, output reg [7:0] q);
    if (sel) ready;
    strobe(1, sel, 8'h00, q);
  endtask
  task automatic pulse_reset;
    @(negedge clk);
    hardware_reset_input = ~hardware_reset_input;
  endtask
endmodule // lcdc_host

/* File: dv/dot_matrix_lcd_command_decoder_tb.sv */
// self-checking bench for the lcd command decoder
// assumes lcdc_host drives the pins and lcdc_sva is bound
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module dot_matrix_lcd_command_decoder_tb;
  logic       clk = 0, sys_rst = 1;
  wire        hri, cds, rd_n, wr_n, on, st, d32, sf;
  wire  [7:0] din, dout, oe_n;
  wire  [4:0] sl, lc;
  int         errors = 0, n_compared = 0, seed = 32'hbd53, ram [0:3][0:80];
  int         col, page, latch, saved, rmw, c, n;
  logic [7:0] q;
  always #25 clk = ~clk;
  lcdc_decoder i_lcdc_decoder (.clk(clk), .sys_rst(sys_rst), .hardware_reset_input(hri),
    .command_data_select(cds), .rd_n(rd_n), .wr_n(wr_n), .data_in(din), .data_out(dout),
    .data_oe_n(oe_n), .display_on(on), .static_drive(st), .duty_32(d32), .seg_forward(sf),
    .start_line(sl), .line_count_m1(lc), .scan_col(), .scan_line(), .scan_data());
  lcdc_host i_lcdc_host (.clk(clk), .data_out(dout), .hardware_reset_input(hri),
    .command_data_select(cds), .rd_n(rd_n), .wr_n(wr_n), .data_in(din));
  task automatic cmd(input logic [7:0] v);
    i_lcdc_host.put(0, v);
    `CHK("ready", 1'b1, i_lcdc_host.k < 80)
    if (v < 8'h50) col = v;
    if (v[7:2] == 6'h2E) page = v[1:0];
    if (v == 8'hE2) page = 3;
    if (v == 8'hE0) begin
      rmw = 1;
      saved = col;
    end
    if (v == 8'hEE) begin
      rmw = 0;
      col = saved;
    end
  endtask
  task automatic wd(input logic [7:0] v);
    i_lcdc_host.put(1, v);
    if (col < 80) ram[page][col++] = v;
  endtask
  task automatic rd(input bit chk);
    i_lcdc_host.get(1, q);
    if (chk) `CHK("data", latch[7:0], q)
    latch = ram[page][col];
    if (!rmw && col < 80) col++;
  endtask
  task automatic sts(input logic [7:0] e);
    i_lcdc_host.ready;
    i_lcdc_host.get(0, q);
    `CHK("status", e, q)
  endtask
  task automatic report_and_stop;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    report_and_stop;
  end
  initial begin
    col = 0;
    page = 3;
    latch = 0;
    rmw = 0;
    repeat (5) @(negedge clk);
    sys_rst = 0;
    i_lcdc_host.pulse_reset;
    sts(8'h60);
    `CHK("line", 5'h01, sl)
    cmd(8'hAF);
    sts(8'h40);
    cmd(8'hA1);
    sts(8'h00);
    cmd(8'hA0);
    `CHK("seg", 1'b1, sf)
    cmd(8'hA5);
    `CHK("static", 1'b1, st)
    cmd(8'hA4);
    cmd(8'hA8);
    `CHK("duty", 5'h0F, lc)
    cmd(8'hA9);
    cmd(8'hD7);
    `CHK("line", 5'h17, sl)
    cmd(8'hE2);
    `CHK("line", 5'h01, sl)
    cmd(8'h55);
    cmd(8'hFF);
    sts(8'h40);
    for (n = 0; n < 3; n++) begin
      cmd(8'hB8 | 8'($random(seed) & 3));
      c = $random(seed) & 8'h3F;
      cmd(8'(c));
      repeat (4) wd(8'($random(seed)));
      cmd(8'(c));
      rd(0);
      repeat (4) rd(1);
    end
    cmd(8'h4F);
    wd(8'h5A);
    wd(8'hA5);
    cmd(8'h4F);
    rd(0);
    rd(1);
    cmd(8'h10);
    wd(8'h81);
    cmd(8'h10);
    cmd(8'hE0);
    rd(0);
    rd(1);
    rd(1);
    wd(8'h3C);
    cmd(8'hEE);
    rd(0);
    rd(1);
    cmd(8'hAE);
    sts(8'h60);
    i_lcdc_host.pulse_reset;
    i_lcdc_host.get(0, q);
    `CHK("reset status", 8'hF0, q)
    sts(8'h60);
    report_and_stop;
  end
endmodule // dot_matrix_lcd_command_decoder_tb
